// ===== ssi_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module ssi_bus_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic ow_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    ow_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic start();
    sda_out = 1'b1;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    sda_out = 1'b0;
    tick(2);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_out = 1'b0;
    tick(1);
    scl_out = 1'b1;
    tick(2);
    sda_out = 1'b1;
    tick(2);
  endtask
  // SDA moves only a cycle after SCL falls
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_out = b;
    tick(1);
    scl_out = 1'b1;
    tick(1);
    r = sda_in;
    tick(1);
    scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask
  // Quarter duty for a zero, three quarters for a one
  task automatic ow_frame(input logic [31:0] f);
    ow_out = 1'b0;
    tick(4);
    for (int i = 31; i >= 0; i--) begin
      ow_out = 1'b1;
      tick(f[i] ? 12 : 4);
      ow_out = 1'b0;
      tick(f[i] ? 4 : 12);
    end
    ow_out = 1'b1;
    tick(48);
  endtask
endmodule
`default_nettype wire

// ===== ssi_consts.svh
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

// Link (internal oscillator) clock period in picoseconds
`define SSI_LINK_PERIOD_PS 6000
// One-wire start pulse, least low time
`define SSI_OWI_START_NS 25000
`define SSI_OWI_START_CYC ((`SSI_OWI_START_NS * 1000 + `SSI_LINK_PERIOD_PS - 1) / `SSI_LINK_PERIOD_PS)
// Startup window and one-wire stop limits, in oscillator clocks
`define SSI_WINDOW_CLKS 52700
`define SSI_SECURE_STOP_CLKS 32766
`define SSI_MIN_BIT_CLKS 80
// Link clocks after reset before the synchronised configuration is trusted
`define SSI_CFG_SETTLE_CLKS 2
// Slave addresses and the enter-command-mode command
`define SSI_ADDR_MAIN 7'h78
`define SSI_ADDR_ALT_HI 3'h7
`define SSI_ENTER_COMMAND_MODE_CMD_CMD 8'h72
`define SSI_ENTER_COMMAND_MODE_CMD_DATA 8'hd1
// Output register bytes repeated on a read
`define SSI_OUT_BYTES 4
// Counter width for one-wire timing and the startup window
`define SSI_CNT_W 16

`endif

// ===== ssi_pkg.sv
package ssi_pkg;

  typedef enum logic [1:0] {
    one_wire_always_on = 2'b00,
    one_wire_startup_window = 2'b01,
    one_wire_window_with_analog = 2'b10,
    one_wire_disabled = 2'b11
  } ssi_ow_mode_e;

  typedef enum logic [2:0] {
    i2c_idle = 3'b000,
    i2c_addr = 3'b001,
    i2c_ack = 3'b010,
    i2c_rx = 3'b011,
    i2c_tx = 3'b100,
    i2c_mack = 3'b101,
    i2c_ignore = 3'b110
  } ssi_i2c_e;

  typedef enum logic [1:0] {
    owi_idle = 2'b00,
    owi_low = 2'b01,
    owi_frame = 2'b10
  } ssi_owi_e;

endpackage

// ===== ssi_serial_slave.sv
// Operation
// - SDA falls while SCL high: start
// - Command released only after stop condition
// - Bytes of eight bits, MSB first, ack
// - SDA changes only while SCL low
// - Receiver pulls SDA low in ack slot
// - No ack while sending: release, stop sending
// - Interface inactive while controller is busy
// - Write: address, command, optional two data
// - Read: address with direction one, data returned
// - Reads served from output registers only
// - Read data repeats until stop condition
// - Output registers refreshed from conditioning results
// - Four one-wire modes selected by configuration
// - Always-on: one-wire pin, analog driver off
// - Window expiry without entry disables one-wire
// - Window-with-analog: analog on, one-wire receptive
// - Startup window 52700 clocks; entry enters command
// - Disabled mode ignores all one-wire traffic
// - Command mode analog request: no window timeout
// - One-wire frames like two-wire, address first
// - One-wire bit timing follows the master
// - Answer address 78 and optional 7x
// - Long low on idle line: start
// - Duty ratio at rising edge decodes bit
// - Stop on constant line, long or short
`timescale 1ns/100ps
`default_nettype none
`include "ssi_consts.svh"

module ssi_serial_slave
  import ssi_pkg::*;
#(
  parameter int OUT_BYTES = `SSI_OUT_BYTES,
  parameter int CW = `SSI_CNT_W,
  parameter int START_LOW_CYC = `SSI_OWI_START_CYC,
  parameter int WINDOW_CLKS = `SSI_WINDOW_CLKS,
  parameter int SECURE_STOP_CLKS = `SSI_SECURE_STOP_CLKS
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic clk_link_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out_out,
  output logic sda_oe_n_out,
  input wire logic shared_output_pin_in,
  input wire logic [1:0] one_wire_mode_select_in,
  input wire logic alt_addr_en_in,
  input wire logic [3:0] alt_addr_in,
  input wire logic busy_in,
  input wire logic analog_req_in,
  input wire logic [8*OUT_BYTES-1:0] out_data_in,
  input wire logic out_load_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  output logic [15:0] cmd_data_out,
  output logic [1:0] cmd_len_out,
  output logic one_wire_link_en_out,
  output logic analog_drive_en_out,
  output logic command_mode_state_out,
  output logic startup_window_open_out
);

  localparam int OW = 8 * OUT_BYTES;
  localparam int IW = (OUT_BYTES > 1) ? $clog2(OUT_BYTES) : 1;
  localparam logic [CW-1:0] WIN_L = CW'(WINDOW_CLKS);
  localparam logic [CW-1:0] SEC_L = CW'(SECURE_STOP_CLKS);
  localparam logic [CW-1:0] STA_L = CW'(START_LOW_CYC);
  localparam logic [CW-1:0] MINB_L = CW'(`SSI_MIN_BIT_CLKS);
  localparam logic [CW-1:0] SETTLE_L = CW'(`SSI_CFG_SETTLE_CLKS);
  localparam logic [IW-1:0] LAST_IDX = IW'(OUT_BYTES - 1);

  typedef struct packed {
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic ow_m;
    logic ow_s;
    logic ow_p;
    logic [1:0] mode_m;
    logic [1:0] mode_s;
    logic [4:0] adr_m;
    logic [4:0] adr_s;
    logic areq_m;
    logic areq_s;
    logic busy_m;
    logic busy_s;
    logic otg_m;
    logic otg_s;
    logic otg_p;
    logic [OW-1:0] out_word;
    ssi_i2c_e ist;
    logic [3:0] ibit;
    logic [7:0] ish;
    logic irw;
    logic [IW-1:0] idx;
    logic sda_oe_n;
    ssi_owi_e ost;
    logic [CW-1:0] rc;
    logic [CW-1:0] ec;
    logic [CW-1:0] hi;
    logic [CW-1:0] per_last;
    logic [2:0] obit;
    logic [7:0] osh;
    logic [2:0] wr_cnt;
    logic wr_ok;
    logic [7:0] wr_cmd;
    logic [7:0] wr_d1;
    logic [7:0] wr_d2;
    logic [7:0] h_cmd;
    logic [15:0] h_data;
    logic [1:0] h_len;
    logic ctg;
    logic [CW-1:0] win;
    logic expired;
    logic cm;
    logic owi_en;
    logic ana_en;
  } ssi_link_s;

  typedef struct packed {
    logic ctg_m;
    logic ctg_s;
    logic ctg_p;
    logic cmd_valid;
    logic [7:0] cmd;
    logic [15:0] data;
    logic [1:0] len;
    logic [OW-1:0] word;
    logic otg;
  } ssi_sys_s;

  ssi_link_s lk;
  ssi_link_s next_lk;
  ssi_sys_s sy;
  ssi_sys_s next_sy;
  logic lrst_m;
  logic lrst;

  function automatic logic addr_hit(input logic [6:0] a, input logic [4:0] alt);
    addr_hit = (a == `SSI_ADDR_MAIN) || (alt[4] && a == {`SSI_ADDR_ALT_HI, alt[3:0]});
  endfunction

  // Reset brought into the link domain
  always_ff @(posedge clk_link_in) begin
    lrst_m <= srst_in;
    lrst <= lrst_m;
  end

  always_comb begin
    logic i_start;
    logic i_stop;
    logic i_rise;
    logic i_fall;
    logic o_rise;
    logic o_fall;
    logic o_stop;
    logic o_bit;
    logic o_ok;
    logic ev_start;
    logic ev_byte;
    logic ev_stop;
    logic [7:0] ev_b;
    logic [7:0] tx_b;
    logic [CW-1:0] per;
    logic [CW+2:0] hi8;
    logic [CW+2:0] p3;
    logic [CW+2:0] p5;
    logic [CW+2:0] p7;
    next_lk = lk;
    ev_start = 1'b0;
    ev_byte = 1'b0;
    ev_stop = 1'b0;
    ev_b = 8'h00;
    o_stop = 1'b0;
    o_bit = 1'b0;
    o_ok = 1'b0;
    // Pin and configuration synchronisers
    next_lk.sda_m = sda_in;
    next_lk.sda_s = lk.sda_m;
    next_lk.sda_p = lk.sda_s;
    next_lk.scl_m = scl_in;
    next_lk.scl_s = lk.scl_m;
    next_lk.scl_p = lk.scl_s;
    next_lk.ow_m = shared_output_pin_in;
    next_lk.ow_s = lk.ow_m;
    next_lk.ow_p = lk.ow_s;
    next_lk.mode_m = one_wire_mode_select_in;
    next_lk.mode_s = lk.mode_m;
    next_lk.adr_m = {alt_addr_en_in, alt_addr_in};
    next_lk.adr_s = lk.adr_m;
    next_lk.areq_m = analog_req_in;
    next_lk.areq_s = lk.areq_m;
    next_lk.busy_m = busy_in;
    next_lk.busy_s = lk.busy_m;
    next_lk.otg_m = sy.otg;
    next_lk.otg_s = lk.otg_m;
    next_lk.otg_p = lk.otg_s;
    if (lk.otg_s != lk.otg_p) begin
      next_lk.out_word = sy.word;
    end

    // Two-wire slave
    i_start = lk.scl_s && lk.scl_p && lk.sda_p && !lk.sda_s;
    i_stop = lk.scl_s && lk.scl_p && !lk.sda_p && lk.sda_s;
    i_rise = lk.scl_s && !lk.scl_p;
    i_fall = !lk.scl_s && lk.scl_p;
    tx_b = lk.out_word[8 * (OUT_BYTES - 1 - int'(lk.idx)) +: 8];
    if (i_start) begin
      next_lk.ist = lk.busy_s ? i2c_ignore : i2c_addr;
      next_lk.ibit = 4'h0;
      next_lk.sda_oe_n = 1'b1;
      ev_start = !lk.busy_s;
    end else if (i_stop) begin
      next_lk.ist = i2c_idle;
      next_lk.sda_oe_n = 1'b1;
      ev_stop = 1'b1;
    end else begin
      unique case (lk.ist)
        i2c_idle, i2c_ignore: begin
          next_lk.sda_oe_n = 1'b1;
        end
        i2c_addr, i2c_rx: begin
          if (i_rise) begin
            next_lk.ish = {lk.ish[6:0], lk.sda_s};
            next_lk.ibit = lk.ibit + 4'h1;
          end else if (i_fall && lk.ibit == 4'h8) begin
            ev_byte = 1'b1;
            ev_b = lk.ish;
            next_lk.ibit = 4'h0;
            if (lk.ist == i2c_rx || addr_hit(lk.ish[7:1], lk.adr_s)) begin
              next_lk.ist = i2c_ack;
              next_lk.sda_oe_n = 1'b0;
              if (lk.ist == i2c_addr) begin
                next_lk.irw = lk.ish[0];
                next_lk.idx = '0;
              end
            end else begin
              next_lk.ist = i2c_ignore;
            end
          end
        end
        i2c_ack: begin
          if (i_fall) begin
            next_lk.ibit = 4'h0;
            if (lk.irw) begin
              next_lk.ist = i2c_tx;
              next_lk.ish = {tx_b[6:0], 1'b0};
              next_lk.sda_oe_n = tx_b[7];
            end else begin
              next_lk.ist = i2c_rx;
              next_lk.sda_oe_n = 1'b1;
            end
          end
        end
        i2c_tx: begin
          if (i_rise) begin
            next_lk.ibit = lk.ibit + 4'h1;
          end else if (i_fall) begin
            if (lk.ibit == 4'h8) begin
              next_lk.ist = i2c_mack;
              next_lk.sda_oe_n = 1'b1;
              next_lk.idx = (lk.idx == LAST_IDX) ? '0 : lk.idx + 1'b1;
            end else begin
              next_lk.sda_oe_n = lk.ish[7];
              next_lk.ish = {lk.ish[6:0], 1'b0};
            end
          end
        end
        i2c_mack: begin
          if (i_rise) begin
            next_lk.ist = lk.sda_s ? i2c_ignore : i2c_ack;
          end
        end
        default: begin
          next_lk.ist = i2c_idle;
          next_lk.sda_oe_n = 1'b1;
        end
      endcase
    end

    // One-wire receiver
    o_rise = lk.ow_s && !lk.ow_p;
    o_fall = !lk.ow_s && lk.ow_p;
    per = lk.rc;
    hi8 = {lk.hi, 3'b000};
    p3 = {2'b00, per, 1'b0} + {3'b000, per};
    p5 = {1'b0, per, 2'b00} + {3'b000, per};
    p7 = {per, 3'b000} - {3'b000, per};
    next_lk.rc = (lk.rc == '1) ? lk.rc : lk.rc + 1'b1;
    next_lk.ec = (o_rise || o_fall) ? '0 : ((lk.ec == '1) ? lk.ec : lk.ec + 1'b1);
    if (!lk.owi_en || lk.busy_s) begin
      next_lk.ost = owi_idle;
    end else begin
      unique case (lk.ost)
        owi_idle: begin
          if (o_fall) begin
            next_lk.ost = owi_low;
            next_lk.rc = '0;
          end
        end
        owi_low: begin
          if (o_rise) begin
            next_lk.rc = '0;
            next_lk.obit = 3'h0;
            next_lk.per_last = '0;
            if (lk.rc >= STA_L) begin
              next_lk.ost = owi_frame;
              ev_start = 1'b1;
            end else begin
              next_lk.ost = owi_idle;
            end
          end
        end
        owi_frame: begin
          if (o_fall) begin
            next_lk.hi = lk.rc;
          end
          if (o_rise) begin
            next_lk.rc = '0;
            if (hi8 > {3'b000, per} && hi8 < p3) begin
              o_ok = 1'b1;
            end else if (hi8 > p5 && hi8 < p7) begin
              o_ok = 1'b1;
              o_bit = 1'b1;
            end
            if (per < MINB_L || !o_ok) begin
              o_stop = 1'b1;
            end else if (lk.per_last != '0 && ({1'b0, per} > {lk.per_last, 1'b0}
                || {per, 1'b0} < {1'b0, lk.per_last})) begin
              o_stop = 1'b1;
            end else begin
              next_lk.per_last = per;
              next_lk.osh = {lk.osh[6:0], o_bit};
              next_lk.obit = lk.obit + 3'h1;
              if (lk.obit == 3'h7) begin
                ev_byte = !ev_byte;
                ev_b = {lk.osh[6:0], o_bit};
              end
            end
          end else if (lk.ec > SEC_L) begin
            o_stop = 1'b1;
          end else if (lk.per_last != '0 && {1'b0, lk.ec} > {lk.per_last, 1'b0}) begin
            o_stop = 1'b1;
          end
          if (o_stop) begin
            next_lk.ost = owi_idle;
            ev_stop = 1'b1;
          end
        end
        default: begin
          next_lk.ost = owi_idle;
        end
      endcase
    end

    // Write command collector shared by both links
    if (ev_start) begin
      next_lk.wr_cnt = 3'h0;
      next_lk.wr_ok = 1'b0;
    end else if (ev_byte) begin
      unique case (lk.wr_cnt)
        3'h0: next_lk.wr_ok = addr_hit(ev_b[7:1], lk.adr_s) && !ev_b[0];
        3'h1: next_lk.wr_cmd = ev_b;
        3'h2: next_lk.wr_d1 = ev_b;
        3'h3: next_lk.wr_d2 = ev_b;
        default: next_lk.wr_ok = 1'b0;
      endcase
      if (lk.wr_cnt != 3'h4) begin
        next_lk.wr_cnt = lk.wr_cnt + 3'h1;
      end
    end else if (ev_stop) begin
      next_lk.wr_ok = 1'b0;
      if (lk.wr_ok && lk.wr_cnt >= 3'h2) begin
        next_lk.h_cmd = lk.wr_cmd;
        next_lk.h_data = {lk.wr_d1, lk.wr_d2};
        next_lk.h_len = 2'(lk.wr_cnt - 3'h1);
        next_lk.ctg = !lk.ctg;
        if (lk.wr_cmd == `SSI_ENTER_COMMAND_MODE_CMD_CMD && lk.wr_d1 == `SSI_ENTER_COMMAND_MODE_CMD_DATA
            && lk.wr_cnt >= 3'h3) begin
          next_lk.cm = 1'b1;
        end
      end
    end

    // Startup window and pin mode
    if (!lk.cm && !lk.expired) begin
      next_lk.win = lk.win + 1'b1;
      next_lk.expired = (lk.win + 1'b1) >= WIN_L;
    end
    unique case (ssi_ow_mode_e'(lk.mode_s))
      one_wire_always_on: begin
        next_lk.owi_en = 1'b1;
        next_lk.ana_en = lk.cm && lk.areq_s;
      end
      one_wire_startup_window: begin
        next_lk.owi_en = lk.cm || !lk.expired;
        next_lk.ana_en = lk.cm ? lk.areq_s : lk.expired;
      end
      one_wire_window_with_analog: begin
        next_lk.owi_en = lk.cm || !lk.expired;
        next_lk.ana_en = lk.cm ? lk.areq_s : 1'b1;
      end
      one_wire_disabled: begin
        next_lk.owi_en = 1'b0;
        next_lk.ana_en = lk.cm ? lk.areq_s : 1'b1;
      end
    endcase
    // Mode synchroniser still holds its reset code: keep link and driver off
    if (!lk.cm && lk.win < SETTLE_L) begin
      next_lk.owi_en = 1'b0;
      next_lk.ana_en = 1'b0;
    end
  end

  always_ff @(posedge clk_link_in) begin
    if (lrst) begin
      lk <= '0;
      lk.sda_oe_n <= 1'b1;
      lk.ist <= i2c_idle;
      lk.ost <= owi_idle;
    end else begin
      lk <= next_lk;
    end
  end

  // System side: command hand-over and output register load
  always_comb begin
    next_sy = sy;
    next_sy.ctg_m = lk.ctg;
    next_sy.ctg_s = sy.ctg_m;
    next_sy.ctg_p = sy.ctg_s;
    next_sy.cmd_valid = sy.ctg_s != sy.ctg_p;
    if (sy.ctg_s != sy.ctg_p) begin
      next_sy.cmd = lk.h_cmd;
      next_sy.data = lk.h_data;
      next_sy.len = lk.h_len;
    end
    if (out_load_in) begin
      next_sy.word = out_data_in;
      next_sy.otg = !sy.otg;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sy <= '0;
    end else begin
      sy <= next_sy;
    end
  end

  assign sda_out_out = 1'b0;
  assign sda_oe_n_out = lk.sda_oe_n;
  assign cmd_valid_out = sy.cmd_valid;
  assign cmd_byte_out = sy.cmd;
  assign cmd_data_out = sy.data;
  assign cmd_len_out = sy.len;
  assign one_wire_link_en_out = lk.owi_en;
  assign analog_drive_en_out = lk.ana_en;
  assign command_mode_state_out = lk.cm;
  assign startup_window_open_out = !lk.expired && !lk.cm;

endmodule

`default_nettype wire

// ===== ssi_serial_slave_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ssi_serial_slave_monitor
  import ssi_pkg::*;
#(
  parameter int WINDOW_CLKS = 52700
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic clk_link_in,
  input wire logic scl_in,
  input wire logic sda_out_out,
  input wire logic sda_oe_n_out,
  input wire logic [1:0] one_wire_mode_select_in,
  input wire logic analog_req_in,
  input wire logic cmd_valid_out,
  input wire logic one_wire_link_en_out,
  input wire logic analog_drive_en_out,
  input wire logic command_mode_state_out,
  input wire logic startup_window_open_out
);
  logic [15:0] win_cnt;
  logic win_mode;
  logic cm;
  assign cm = command_mode_state_out;
  assign win_mode = (one_wire_mode_select_in == one_wire_startup_window) ||
    (one_wire_mode_select_in == one_wire_window_with_analog);
  // Link clocks spent with the window open since reset
  always_ff @(posedge clk_link_in) begin
    win_cnt <= srst_in ? 16'h0 : win_cnt + 16'(startup_window_open_out);
  end
  a_open_drain: assert property (@(posedge clk_link_in) disable iff (srst_in)
    !sda_out_out) else $error("SDA data driven high");
  a_sda_scl_low: assert property (@(posedge clk_link_in) disable iff (srst_in)
    $changed(sda_oe_n_out) |-> !scl_in) else $error("SDA changed with SCL high");
  a_cmd_pulse: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    cmd_valid_out |=> !cmd_valid_out) else $error("Command strobe too long");
  a_disabled_off: assert property (@(posedge clk_link_in) disable iff (srst_in)
    one_wire_mode_select_in == one_wire_disabled |-> !one_wire_link_en_out)
    else $error("Link on in disabled mode");
  a_always_on_pin: assert property (@(posedge clk_link_in) disable iff (srst_in)
    one_wire_mode_select_in == one_wire_always_on && !cm |-> !analog_drive_en_out)
    else $error("Analog on in always-on mode");
  a_expiry_switch: assert property (@(posedge clk_link_in) disable iff (srst_in)
    $fell(startup_window_open_out) && win_mode && !cm |->
    ##[0:4] (!one_wire_link_en_out && analog_drive_en_out)) else $error("Bad expiry");
  a_window_len: assert property (@(posedge clk_link_in) disable iff (srst_in)
    $fell(startup_window_open_out) && win_mode && !cm |->
    win_cnt >= WINDOW_CLKS - 1 && win_cnt <= WINDOW_CLKS + 6) else $error("Window length");
  a_cm_analog: assert property (@(posedge clk_link_in) disable iff (srst_in)
    (cm && analog_req_in) [*6] |-> analog_drive_en_out) else $error("No analog request");
endmodule
bind ssi_serial_slave ssi_serial_slave_monitor #(.WINDOW_CLKS(WINDOW_CLKS)) u_mon (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .clk_link_in(clk_link_in), .scl_in(scl_in),
  .sda_out_out(sda_out_out), .sda_oe_n_out(sda_oe_n_out), .analog_req_in(analog_req_in),
  .one_wire_mode_select_in(one_wire_mode_select_in), .cmd_valid_out(cmd_valid_out),
  .one_wire_link_en_out(one_wire_link_en_out), .analog_drive_en_out(analog_drive_en_out),
  .command_mode_state_out(command_mode_state_out),
  .startup_window_open_out(startup_window_open_out));
`default_nettype wire

// ===== ssi_serial_slave_test.sv
`timescale 1ns/100ps
`default_nettype none
module ssi_serial_slave_test
  import ssi_pkg::*;
;
  logic clk, clk_link, srst, scl, sda, sda_m, ow, alt_en, busy, areq, oload;
  logic sda_o, sda_oe_n, cmd_valid, link_en, analog_en, cm_state, win_open;
  logic [1:0] mode;
  logic [1:0] cmd_len;
  logic [3:0] alt;
  logic [7:0] cmd_byte;
  logic [15:0] cmd_data;
  logic [31:0] odata;
  logic [6:0] ta [3] = '{7'h75, 7'h73, 7'h78};
  int n_errors = 0;
  int tests_run = 0;
  int n_cmd = 0;
  assign sda = sda_m & (sda_oe_n | sda_o);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    clk_link = 1'b0;
    #1.7;
    forever #3 clk_link = ~clk_link;
  end
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd <= n_cmd + 1;
    end
  end
  ssi_bus_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_m), .ow_out(ow));
  ssi_serial_slave #(.START_LOW_CYC(20), .WINDOW_CLKS(300), .SECURE_STOP_CLKS(2000)) uut (
    .clk_sys_in(clk), .srst_in(srst), .clk_link_in(clk_link), .scl_in(scl), .sda_in(sda),
    .sda_out_out(sda_o), .sda_oe_n_out(sda_oe_n), .shared_output_pin_in(ow),
    .one_wire_mode_select_in(mode), .alt_addr_en_in(alt_en), .alt_addr_in(alt),
    .busy_in(busy), .analog_req_in(areq), .out_data_in(odata), .out_load_in(oload),
    .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte), .cmd_data_out(cmd_data),
    .cmd_len_out(cmd_len), .one_wire_link_en_out(link_en), .analog_drive_en_out(analog_en),
    .command_mode_state_out(cm_state), .startup_window_open_out(win_open));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rst(input logic [1:0] md);
    m.tick(1);
    srst = 1'b1;
    mode = md;
    m.tick(6);
    srst = 1'b0;
    m.tick(3);
  endtask
  task automatic wr(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic a;
    m.xfer(d, 1'b1, q, a);
    chk("ack", e, a);
  endtask
  task automatic rd(input logic [7:0] e, input logic nack);
    logic [7:0] q;
    logic a;
    m.xfer(8'hff, nack, q, a);
    chk("read byte", e, q);
  endtask
  task automatic wait_cmd(input int k);
    int i;
    i = 0;
    while (n_cmd < k && i < 40) begin
      m.tick(1);
      i++;
    end
    chk("command count", k, n_cmd);
  endtask
  task automatic chk_cmd();
    chk("command byte", 8'h72, cmd_byte);
    chk("command data", 16'hd15a, cmd_data);
    chk("command mode", 1'b1, cm_state);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    mode = 2'h0;
    alt_en = 1'b0;
    alt = 4'h0;
    busy = 1'b0;
    areq = 1'b0;
    oload = 1'b0;
    odata = 32'ha1b2c3d4;
    for (int md = 0; md < 4; md++) begin
      rst(2'(md));
      chk("link in window", 4'b0111 >> md & 1, link_en);
      chk("analog in window", 4'b1100 >> md & 1, analog_en);
      chk("window open", 1'b1, win_open);
      m.tick(60);
      chk("link after window", 4'b0001 >> md & 1, link_en);
      chk("analog after window", 4'b1110 >> md & 1, analog_en);
      chk("window closed", 1'b0, win_open);
    end
    $display("mode test done");
    rst(one_wire_always_on);
    m.tick(60);
    oload = 1'b1;
    m.tick(1);
    oload = 1'b0;
    m.start();
    wr(8'hf0, 1'b0);
    wr(8'h72, 1'b0);
    wr(8'hd1, 1'b0);
    wr(8'h5a, 1'b0);
    m.tick(20);
    chk("command before stop", 0, n_cmd);
    m.stop();
    wait_cmd(1);
    chk_cmd();
    chk("command length", 2'h3, cmd_len);
    $display("write test done");
    m.start();
    wr(8'hf1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rd(odata[31 - 8 * (i % 4) -: 8], i == 4);
    end
    m.stop();
    odata = 32'h0f1e2d3c;
    oload = 1'b1;
    m.tick(1);
    oload = 1'b0;
    m.start();
    wr(8'hf1, 1'b0);
    rd(odata[31:24], 1'b1);
    rd(8'hff, 1'b1);
    m.stop();
    $display("read test done");
    for (int i = 0; i < 3; i++) begin
      alt_en = (i == 1);
      alt = ta[i][3:0];
      busy = (i == 2);
      m.start();
      wr({ta[i], 1'b0}, i != 1);
      m.stop();
    end
    busy = 1'b0;
    chk("refused frames", 1, n_cmd);
    areq = 1'b1;
    m.tick(4);
    chk("analog on request", 1'b1, analog_en);
    chk("link on request", 1'b1, link_en);
    areq = 1'b0;
    $display("address test done");
    rst(one_wire_always_on);
    m.tick(60);
    m.ow_frame(32'hf072d15a);
    wait_cmd(2);
    chk_cmd();
    rst(one_wire_disabled);
    m.tick(60);
    m.ow_frame(32'hf072d15a);
    wait_cmd(2);
    chk("mode disabled", 1'b0, cm_state);
    $display("one-wire test done");
    end_of_test();
  end
endmodule
`default_nettype wire
